// >>> dscr_pkg.sv
/*
  shared constants and carrier types for the drive serial command register front end.
  assumes one 40 MHz clock and a synchronous active-low reset in dscr_regs; the crc and command decode modules are combinational.
*/
package dscr_pkg;

  localparam logic [15:0] DSCR_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] DSCR_CRC_POLY = 16'hA001;
  localparam logic [15:0] DSCR_CRC_RESIDUE = 16'h0000;
  localparam logic [15:0] DSCR_CRC_OF_01 = 16'h807E;

  localparam logic [15:0] DSCR_CMD_ADDR = 16'h2000;
  localparam logic [15:0] DSCR_FREQ_ADDR = 16'h2001;
  localparam logic [15:0] DSCR_FAULT_ADDR = 16'h2002;
  localparam logic [7:0] DSCR_PARAM_GROUP_LIMIT = 8'h20;

  localparam logic [7:0] DSCR_FN_READ = 8'h03;
  localparam logic [7:0] DSCR_FN_WRITE = 8'h06;
  localparam logic [7:0] DSCR_FN_EXC = 8'h80;
  localparam logic [7:0] DSCR_EXC_FUNC = 8'h01;
  localparam logic [7:0] DSCR_EXC_ADDR = 8'h02;
  localparam logic [7:0] DSCR_EXC_VALUE = 8'h03;
  localparam logic [7:0] DSCR_READ_BYTES = 8'h02;
  localparam logic [15:0] DSCR_READ_COUNT = 16'h0001;

  localparam int DSCR_REQ_BYTES = 8;
  localparam logic [3:0] DSCR_REQ_LEN = 4'h8;
  localparam logic [3:0] DSCR_ECHO_LEN = 4'h6;
  localparam logic [3:0] DSCR_RDRSP_LEN = 4'h5;
  localparam logic [3:0] DSCR_EXC_LEN = 4'h3;

  localparam int DSCR_RUN_LSB = 0;
  localparam int DSCR_DIR_LSB = 4;
  localparam int DSCR_ACC_LSB = 6;
  localparam int DSCR_STEP_LSB = 8;
  localparam int DSCR_GATE_BIT = 12;
  localparam int DSCR_RAISE_BIT = 0;
  localparam int DSCR_RST_BIT = 1;

  localparam logic [1:0] DSCR_ACT_STOP = 2'h1;
  localparam logic [1:0] DSCR_ACT_RUN = 2'h2;
  localparam logic [1:0] DSCR_ACT_JOG = 2'h3;
  localparam logic [1:0] DSCR_DIR_FORWARD = 2'h1;
  localparam logic [1:0] DSCR_DIR_REVERSE = 2'h2;
  localparam logic [1:0] DSCR_DIR_TOG = 2'h3;

  localparam logic [15:0] DSCR_FREQ_RST = 16'h0000;

  typedef enum logic [1:0] {
    DSCR_S_RX = 2'b00,
    DSCR_S_EXEC = 2'b01,
    DSCR_S_PRD = 2'b10,
    DSCR_S_TX = 2'b11
  } dscr_state_e;

  typedef enum logic [2:0] {
    DSCR_CLS_PARAM = 3'b000,
    DSCR_CLS_CMD = 3'b001,
    DSCR_CLS_FREQ = 3'b010,
    DSCR_CLS_FAULT = 3'b011,
    DSCR_CLS_NONE = 3'b100
  } dscr_class_e;

  typedef struct packed {
    logic run;
    logic jog;
    logic forward_rotation;
    logic reverse_rotation;
    logic [1:0] accel_set;
    logic [3:0] step_speed;
    logic comm_override;
  } dscr_drive_s;

  localparam dscr_drive_s DSCR_DRIVE_RST = '{run: 1'b0, jog: 1'b0, forward_rotation: 1'b1,
    reverse_rotation: 1'b0, accel_set: 2'h0, step_speed: 4'h0, comm_override: 1'b0};

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] group_number_address;
    logic [15:0] wdata;
  } dscr_param_s;

  localparam dscr_param_s DSCR_PARAM_RST = '{rd: 1'b0, wr: 1'b0, group_number_address: 16'h0000,
    wdata: 16'h0000};

endpackage

// >>> dscr_crc_byte.sv
/*
  one byte of the reflected crc-16 update, fully combinational.
  assumes the caller registers the result and seeds it with the all-ones value.
*/
`timescale 1ns/1ps
module dscr_crc_byte (
  input wire logic [15:0] crc_in,
  input wire logic [7:0] data,
  output logic [15:0] crc_out
);

  logic [15:0] acc;

  always_comb begin
    acc = crc_in ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      if (acc[0]) begin
        acc = (acc >> 1) ^ dscr_pkg::DSCR_CRC_POLY;
      end else begin
        acc = acc >> 1;
      end
    end
    crc_out = acc;
  end

endmodule

// >>> dscr_cmd_decode.sv
/*
  decodes a write to the drive command word into the next drive state.
  assumes the caller applies the result only on a command word write.
*/
`timescale 1ns/1ps
module dscr_cmd_decode (
  input wire logic [15:0] word,
  input wire dscr_pkg::dscr_drive_s cur,
  output dscr_pkg::dscr_drive_s nxt
);

  always_comb begin
    nxt = cur;
    case (word[dscr_pkg::DSCR_RUN_LSB +: 2])
      dscr_pkg::DSCR_ACT_STOP: begin
        nxt.run = 1'b0;
        nxt.jog = 1'b0;
      end
      dscr_pkg::DSCR_ACT_RUN: begin
        nxt.run = 1'b1;
        nxt.jog = 1'b0;
      end
      dscr_pkg::DSCR_ACT_JOG: begin
        nxt.run = 1'b1;
        nxt.jog = 1'b1;
      end
      default: begin
      end
    endcase
    case (word[dscr_pkg::DSCR_DIR_LSB +: 2])
      dscr_pkg::DSCR_DIR_FORWARD: begin
        nxt.forward_rotation = 1'b1;
        nxt.reverse_rotation = 1'b0;
      end
      dscr_pkg::DSCR_DIR_REVERSE: begin
        nxt.forward_rotation = 1'b0;
        nxt.reverse_rotation = 1'b1;
      end
      dscr_pkg::DSCR_DIR_TOG: begin
        nxt.forward_rotation = cur.reverse_rotation;
        nxt.reverse_rotation = cur.forward_rotation;
      end
      default: begin
      end
    endcase
    // bits 2-3 and 13-15 reserved, simply not looked at
    nxt.comm_override = word[dscr_pkg::DSCR_GATE_BIT];
    if (word[dscr_pkg::DSCR_GATE_BIT]) begin
      nxt.accel_set = word[dscr_pkg::DSCR_ACC_LSB +: 2];
      nxt.step_speed = word[dscr_pkg::DSCR_STEP_LSB +: 4];
    end
  end

endmodule

// >>> dscr_regs.sv
/*
  rtu slave front end: takes request bytes, checks crc, decodes addresses, answers with a crc.
  assumes a same-clock uart receiver giving bytes and an end-of-frame pulse after line silence,
  a same-clock transmitter with valid/ready, and a parameter store answering reads in the same cycle.
*/
`timescale 1ns/1ps
module dscr_regs (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [7:0] slave_addr,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_frame_end,
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  output dscr_pkg::dscr_drive_s drive,
  output logic [15:0] frequency_setpoint,
  output logic external_fault_flag,
  output logic fault_reset,
  output dscr_pkg::dscr_param_s param,
  input wire logic [15:0] param_rdata
);

  function automatic dscr_pkg::dscr_class_e addr_class(input logic [15:0] a);
    if (a == dscr_pkg::DSCR_CMD_ADDR) begin
      return dscr_pkg::DSCR_CLS_CMD;
    end else if (a == dscr_pkg::DSCR_FREQ_ADDR) begin
      return dscr_pkg::DSCR_CLS_FREQ;
    end else if (a == dscr_pkg::DSCR_FAULT_ADDR) begin
      return dscr_pkg::DSCR_CLS_FAULT;
    end else if (a[15:8] >= dscr_pkg::DSCR_PARAM_GROUP_LIMIT) begin
      return dscr_pkg::DSCR_CLS_NONE;
    end
    return dscr_pkg::DSCR_CLS_PARAM;
  endfunction

  dscr_pkg::dscr_state_e state, next_state;
  logic [7:0] rxb [dscr_pkg::DSCR_REQ_BYTES];
  logic [7:0] next_rxb [dscr_pkg::DSCR_REQ_BYTES];
  logic [7:0] txb [dscr_pkg::DSCR_REQ_BYTES];
  logic [7:0] next_txb [dscr_pkg::DSCR_REQ_BYTES];
  logic [3:0] rx_cnt, next_rx_cnt;
  logic [15:0] rx_crc, next_rx_crc, rx_crc_step;
  logic [3:0] tx_len, next_tx_len;
  logic [3:0] tx_idx, next_tx_idx, tx_nidx;
  logic [15:0] tx_crc, next_tx_crc, tx_crc_step, tx_ncrc;
  logic next_tx_valid;
  logic [7:0] next_tx_data;
  dscr_pkg::dscr_drive_s next_drive, dec_drive;
  logic [15:0] next_freq;
  logic next_fault_flag, next_freset;
  dscr_pkg::dscr_param_s next_param;
  logic [7:0] fn, exc_code;
  logic [15:0] req_addr, req_val;
  dscr_pkg::dscr_class_e cls;
  logic exc, cmd_we, freq_we, fault_we;

  assign fn = rxb[1];
  assign req_addr = {rxb[2], rxb[3]};
  assign req_val = {rxb[4], rxb[5]};
  assign cls = addr_class(req_addr);

  dscr_crc_byte u_rx_crc (
    .crc_in(rx_crc),
    .data(rx_data),
    .crc_out(rx_crc_step)
  );

  dscr_crc_byte u_tx_crc (
    .crc_in(tx_crc),
    .data(tx_data),
    .crc_out(tx_crc_step)
  );

  dscr_cmd_decode u_decode (
    .word(req_val),
    .cur(drive),
    .nxt(dec_drive)
  );

  always_comb begin
    next_state = state;
    next_rxb = rxb;
    next_txb = txb;
    next_rx_cnt = rx_cnt;
    next_rx_crc = rx_crc;
    next_tx_len = tx_len;
    next_tx_idx = tx_idx;
    next_tx_crc = tx_crc;
    next_tx_valid = tx_valid;
    next_tx_data = tx_data;
    next_drive = drive;
    next_freq = frequency_setpoint;
    next_fault_flag = external_fault_flag;
    next_freset = 1'b0;
    next_param = param;
    next_param.rd = 1'b0;
    next_param.wr = 1'b0;
    exc = 1'b0;
    exc_code = dscr_pkg::DSCR_EXC_FUNC;
    cmd_we = 1'b0;
    freq_we = 1'b0;
    fault_we = 1'b0;
    tx_nidx = tx_idx + 4'h1;
    tx_ncrc = (tx_idx < tx_len) ? tx_crc_step : tx_crc;
    case (state)
      dscr_pkg::DSCR_S_RX: begin
        // end of frame wins over a byte in the same cycle; that byte is dropped
        if (rx_frame_end) begin
          if (rx_cnt == dscr_pkg::DSCR_REQ_LEN && rx_crc == dscr_pkg::DSCR_CRC_RESIDUE &&
              rxb[0] == slave_addr) begin
            next_state = dscr_pkg::DSCR_S_EXEC;
          end
          next_rx_cnt = 4'h0;
          next_rx_crc = dscr_pkg::DSCR_CRC_INIT;
        end else if (rx_valid) begin
          if (rx_cnt < dscr_pkg::DSCR_REQ_LEN) begin
            next_rxb[rx_cnt[2:0]] = rx_data;
          end
          // saturates one past the request length so long frames fail the length check
          if (rx_cnt <= dscr_pkg::DSCR_REQ_LEN) begin
            next_rx_cnt = rx_cnt + 4'h1;
          end
          next_rx_crc = rx_crc_step;
        end
      end
      dscr_pkg::DSCR_S_EXEC: begin
        next_txb[0] = rxb[0];
        next_txb[1] = fn;
        next_txb[2] = rxb[2];
        next_txb[3] = rxb[3];
        next_txb[4] = rxb[4];
        next_txb[5] = rxb[5];
        next_tx_len = dscr_pkg::DSCR_ECHO_LEN;
        next_state = dscr_pkg::DSCR_S_TX;
        if (fn == dscr_pkg::DSCR_FN_WRITE) begin
          case (cls)
            dscr_pkg::DSCR_CLS_CMD: begin
              cmd_we = 1'b1;
              next_drive = dec_drive;
            end
            dscr_pkg::DSCR_CLS_FREQ: begin
              freq_we = 1'b1;
              next_freq = req_val;
            end
            dscr_pkg::DSCR_CLS_FAULT: begin
              fault_we = 1'b1;
              next_freset = req_val[dscr_pkg::DSCR_RST_BIT];
              // raise beats clear when both bits are written together
              if (req_val[dscr_pkg::DSCR_RAISE_BIT]) begin
                next_fault_flag = 1'b1;
              end else if (req_val[dscr_pkg::DSCR_RST_BIT]) begin
                next_fault_flag = 1'b0;
              end
            end
            dscr_pkg::DSCR_CLS_PARAM: begin
              next_param.wr = 1'b1;
              next_param.group_number_address = req_addr;
              next_param.wdata = req_val;
            end
            default: begin
              exc = 1'b1;
              exc_code = dscr_pkg::DSCR_EXC_ADDR;
            end
          endcase
        end else if (fn == dscr_pkg::DSCR_FN_READ) begin
          if (req_val != dscr_pkg::DSCR_READ_COUNT) begin
            exc = 1'b1;
            exc_code = dscr_pkg::DSCR_EXC_VALUE;
          end else if (cls == dscr_pkg::DSCR_CLS_PARAM) begin
            next_param.rd = 1'b1;
            next_param.group_number_address = req_addr;
            next_state = dscr_pkg::DSCR_S_PRD;
          end else begin
            // write-only words never leak their contents
            exc = 1'b1;
            exc_code = dscr_pkg::DSCR_EXC_ADDR;
          end
        end else begin
          exc = 1'b1;
        end
        if (exc) begin
          next_txb[1] = fn | dscr_pkg::DSCR_FN_EXC;
          next_txb[2] = exc_code;
          next_tx_len = dscr_pkg::DSCR_EXC_LEN;
        end
        if (next_state == dscr_pkg::DSCR_S_TX) begin
          next_tx_valid = 1'b1;
          next_tx_data = rxb[0];
          next_tx_idx = 4'h0;
          next_tx_crc = dscr_pkg::DSCR_CRC_INIT;
        end
      end
      dscr_pkg::DSCR_S_PRD: begin
        next_txb[2] = dscr_pkg::DSCR_READ_BYTES;
        next_txb[3] = param_rdata[15:8];
        next_txb[4] = param_rdata[7:0];
        next_tx_len = dscr_pkg::DSCR_RDRSP_LEN;
        next_state = dscr_pkg::DSCR_S_TX;
        next_tx_valid = 1'b1;
        next_tx_data = txb[0];
        next_tx_idx = 4'h0;
        next_tx_crc = dscr_pkg::DSCR_CRC_INIT;
      end
      dscr_pkg::DSCR_S_TX: begin
        if (tx_valid && tx_ready) begin
          next_tx_idx = tx_nidx;
          next_tx_crc = tx_ncrc;
          if (tx_nidx < tx_len) begin
            next_tx_data = txb[tx_nidx[2:0]];
          end else if (tx_nidx == tx_len) begin
            next_tx_data = tx_ncrc[7:0];
          end else if (tx_nidx == tx_len + 4'h1) begin
            next_tx_data = tx_ncrc[15:8];
          end else begin
            next_tx_valid = 1'b0;
            next_state = dscr_pkg::DSCR_S_RX;
          end
        end
      end
      default: begin
        next_state = dscr_pkg::DSCR_S_RX;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= dscr_pkg::DSCR_S_RX;
      for (int i = 0; i < dscr_pkg::DSCR_REQ_BYTES; i++) begin
        rxb[i] <= 8'h00;
        txb[i] <= 8'h00;
      end
      rx_cnt <= 4'h0;
      rx_crc <= dscr_pkg::DSCR_CRC_INIT;
      tx_len <= 4'h0;
      tx_idx <= 4'h0;
      tx_crc <= dscr_pkg::DSCR_CRC_INIT;
      tx_valid <= 1'b0;
      tx_data <= 8'h00;
      drive <= dscr_pkg::DSCR_DRIVE_RST;
      frequency_setpoint <= dscr_pkg::DSCR_FREQ_RST;
      external_fault_flag <= 1'b0;
      fault_reset <= 1'b0;
      param <= dscr_pkg::DSCR_PARAM_RST;
    end else begin
      state <= next_state;
      rxb <= next_rxb;
      txb <= next_txb;
      rx_cnt <= next_rx_cnt;
      rx_crc <= next_rx_crc;
      tx_len <= next_tx_len;
      tx_idx <= next_tx_idx;
      tx_crc <= next_tx_crc;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
      drive <= next_drive;
      frequency_setpoint <= next_freq;
      external_fault_flag <= next_fault_flag;
      fault_reset <= next_freset;
      param <= next_param;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  crc_seed_a: assert property (state == dscr_pkg::DSCR_S_RX && rx_frame_end |=> rx_crc == 16'hFFFF)
    else $error("crc not reseeded after frame end");
  crc_vector_a: assert property (state == dscr_pkg::DSCR_S_RX && rx_valid && !rx_frame_end &&
      rx_crc == dscr_pkg::DSCR_CRC_INIT && rx_data == 8'h01 |=> rx_crc == dscr_pkg::DSCR_CRC_OF_01)
    else $error("crc of first byte wrong");
  crc_low_first_a: assert property (state == dscr_pkg::DSCR_S_TX && tx_valid && tx_ready &&
      tx_idx + 4'h1 == tx_len |=> tx_data == tx_crc[7:0] ##0 tx_valid)
    else $error("crc low byte not sent first");
  crc_high_next_a: assert property (state == dscr_pkg::DSCR_S_TX && tx_valid && tx_ready &&
      tx_idx == tx_len |=> tx_data == $past(tx_crc[15:8]) ##0 tx_valid)
    else $error("crc high byte not sent second");
  param_addr_a: assert property (param.wr || param.rd |->
      param.group_number_address == {$past(rxb[2]), $past(rxb[3])})
    else $error("parameter address not group and number");
  single_read_a: assert property (state == dscr_pkg::DSCR_S_EXEC && fn == dscr_pkg::DSCR_FN_READ &&
      req_val != dscr_pkg::DSCR_READ_COUNT |=> !param.rd && tx_valid && txb[2] == dscr_pkg::DSCR_EXC_VALUE)
    else $error("multi register read not refused");
  run_decode_a: assert property (cmd_we && req_val[1:0] == 2'h3 |=> drive.run && drive.jog)
    else $error("jog plus run not decoded");
  dir_toggle_a: assert property (cmd_we && req_val[5:4] == 2'h3 |=>
      drive.forward_rotation != $past(drive.forward_rotation) && drive.reverse_rotation != drive.forward_rotation)
    else $error("direction toggle failed");
  fields_apply_a: assert property (cmd_we && req_val[12] |=>
      drive.accel_set == $past(req_val[7:6]) && drive.step_speed == $past(req_val[11:8]))
    else $error("gated fields not applied");
  fields_hold_a: assert property (cmd_we && !req_val[12] |=> $stable(drive.accel_set) &&
      $stable(drive.step_speed) && !drive.comm_override)
    else $error("ungated fields changed");
  fault_raise_a: assert property (fault_we && req_val[0] |=> external_fault_flag ##1 $stable(external_fault_flag))
    else $error("external fault not raised");
  wo_read_a: assert property (state == dscr_pkg::DSCR_S_EXEC && fn == dscr_pkg::DSCR_FN_READ &&
      req_val == dscr_pkg::DSCR_READ_COUNT && cls != dscr_pkg::DSCR_CLS_PARAM |=>
      txb[1] == (dscr_pkg::DSCR_FN_READ | dscr_pkg::DSCR_FN_EXC) && tx_len == dscr_pkg::DSCR_EXC_LEN)
    else $error("write only word read without exception");
  freq_latch_a: assert property (freq_we |=> frequency_setpoint == $past(req_val) ##1 $stable(frequency_setpoint))
    else $error("frequency setpoint not latched");

  cmd_write_c: cover property (cmd_we);
  param_read_c: cover property (param.rd ##1 state == dscr_pkg::DSCR_S_TX);
  exc_reply_c: cover property (state == dscr_pkg::DSCR_S_EXEC && exc);
  frame_done_c: cover property (tx_valid ##1 !tx_valid && state == dscr_pkg::DSCR_S_RX);

endmodule

// >>> dscr_master_model.sv
/*
  remote rtu master model: frames requests with their crc and takes the answer, stalling on request.
  assumes the block samples on the rising edge; this model moves its lines on the falling edge.
*/
`timescale 1ns/1ps
module dscr_master_model (
  input wire logic clk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_frame_end,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  logic [7:0] rsp[$];
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h5A;
    rx_frame_end = 1'b0;
    tx_ready = 1'b0;
  end
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i]) begin
      c = c ^ {8'h00, b[i]};
      for (int j = 0; j < 8; j++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // crc spoilt only when asked, so a bad frame can be offered
  task automatic send(input logic [7:0] f[$], input logic bad);
    logic [15:0] c;
    c = crc16(f) ^ {15'h0000, bad};
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i]) begin
      @(negedge clk);
      rx_valid = 1'b1;
      rx_data = f[i];
    end
    @(negedge clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data;
    rx_frame_end = 1'b1;
    @(negedge clk);
    rx_frame_end = 1'b0;
  endtask
  // slow above zero raises ready only one cycle in every slow, like a busy transmitter
  task automatic get_rsp(input int n, input int slow);
    int w;
    rsp.delete();
    w = 0;
    while (rsp.size() < n && w < 300) begin
      @(negedge clk);
      tx_ready = (slow == 0) || (w % slow == 0);
      // byte stands until the next rising edge takes it, so read it settled here
      if (tx_valid === 1'b1 && tx_ready === 1'b1) rsp.push_back(tx_data);
      w++;
    end
    @(negedge clk);
    tx_ready = 1'b0;
  endtask
endmodule

// >>> dscr_regs_tb.sv
/*
  self-checking bench for the drive serial command register front end.
  assumes dscr_pkg and the master model come first; station address fixed at 01h.
*/
`timescale 1ns/1ps
module dscr_regs_tb;
  typedef struct packed {
    logic [7:0] fn;
    logic [15:0] adr;
    logic [15:0] val;
    logic [7:0] exc;
    logic [10:0] drv;
    logic [15:0] frq;
    logic flag;
    logic pulse;
  } dscr_row_s;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic rx_valid, rx_frame_end, tx_valid, tx_ready, external_fault_flag, fault_reset;
  logic [7:0] rx_data, tx_data;
  logic [15:0] frequency_setpoint;
  logic [15:0] param_rdata = 16'h0000;
  dscr_pkg::dscr_drive_s drive;
  dscr_pkg::dscr_param_s param;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int n_rst = 0;
  int n_rd = 0;
  int n_wr = 0;
  logic [7:0] f[$];
  // drv packs run, jog, forward, reverse, accel set, step, override
  dscr_row_s rows[25] = '{
    '{8'h06, 16'h2000, 16'h0002, 8'h00, 11'h500, 16'h0000, 1'b0, 1'b0},
    '{8'h06, 16'h2000, 16'h0003, 8'h00, 11'h700, 16'h0000, 1'b0, 1'b0},
    '{8'h06, 16'h2000, 16'h0020, 8'h00, 11'h680, 16'h0000, 1'b0, 1'b0},
    '{8'h06, 16'h2000, 16'h0010, 8'h00, 11'h700, 16'h0000, 1'b0, 1'b0},
    '{8'h06, 16'h2000, 16'h0030, 8'h00, 11'h680, 16'h0000, 1'b0, 1'b0},
    '{8'h06, 16'h2000, 16'h1BC1, 8'h00, 11'h0F7, 16'h0000, 1'b0, 1'b0},
    '{8'h06, 16'h2000, 16'h0F52, 8'h00, 11'h576, 16'h0000, 1'b0, 1'b0},
    '{8'h06, 16'h2000, 16'h000C, 8'h00, 11'h576, 16'h0000, 1'b0, 1'b0},
    '{8'h06, 16'h2000, 16'h1F00, 8'h00, 11'h51F, 16'h0000, 1'b0, 1'b0},
    '{8'h06, 16'h2000, 16'h1A40, 8'h00, 11'h535, 16'h0000, 1'b0, 1'b0},
    '{8'h06, 16'h2000, 16'h1080, 8'h00, 11'h541, 16'h0000, 1'b0, 1'b0},
    '{8'h06, 16'h2001, 16'h1234, 8'h00, 11'h541, 16'h1234, 1'b0, 1'b0},
    '{8'h06, 16'h2001, 16'hFFFF, 8'h00, 11'h541, 16'hFFFF, 1'b0, 1'b0},
    '{8'h06, 16'h2002, 16'h0001, 8'h00, 11'h541, 16'hFFFF, 1'b1, 1'b0},
    '{8'h06, 16'h2002, 16'h0003, 8'h00, 11'h541, 16'hFFFF, 1'b1, 1'b1},
    '{8'h06, 16'h2002, 16'hFFFC, 8'h00, 11'h541, 16'hFFFF, 1'b1, 1'b0},
    '{8'h06, 16'h2002, 16'h0002, 8'h00, 11'h541, 16'hFFFF, 1'b0, 1'b1},
    '{8'h03, 16'h0401, 16'h0001, 8'h00, 11'h541, 16'hFFFF, 1'b0, 1'b0},
    '{8'h03, 16'h0401, 16'h0002, 8'h03, 11'h541, 16'hFFFF, 1'b0, 1'b0},
    '{8'h03, 16'h2000, 16'h0001, 8'h02, 11'h541, 16'hFFFF, 1'b0, 1'b0},
    '{8'h03, 16'h2001, 16'h0001, 8'h02, 11'h541, 16'hFFFF, 1'b0, 1'b0},
    '{8'h03, 16'h2002, 16'h0001, 8'h02, 11'h541, 16'hFFFF, 1'b0, 1'b0},
    '{8'h06, 16'h3000, 16'h0001, 8'h02, 11'h541, 16'hFFFF, 1'b0, 1'b0},
    '{8'h05, 16'h0401, 16'h0001, 8'h01, 11'h541, 16'hFFFF, 1'b0, 1'b0},
    '{8'h06, 16'h0105, 16'hABCD, 8'h00, 11'h541, 16'hFFFF, 1'b0, 1'b0}};

  always #12.5 clk = ~clk;
  dscr_regs DUT (.clk(clk), .nrst(nrst), .slave_addr(8'h01), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_frame_end(rx_frame_end), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .drive(drive),
    .frequency_setpoint(frequency_setpoint), .external_fault_flag(external_fault_flag),
    .fault_reset(fault_reset), .param(param), .param_rdata(param_rdata));
  dscr_master_model master (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_end(rx_frame_end),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

  // parameter store stand-in: data is the address with its bytes swapped
  always @(negedge clk) param_rdata <= {param.group_number_address[7:0], param.group_number_address[15:8]};
  always @(negedge clk) begin
    cycles++;
    if (fault_reset === 1'b1) n_rst++;
    if (param.rd === 1'b1) n_rd++;
    if (param.wr === 1'b1) n_wr++;
    if (cycles == 6000) begin
      errors++;
      end_of_test();
    end
  end

  task automatic chk_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chk_rsp(input logic [7:0] e[$]);
    chk_val("answer length", 16'(e.size()), 16'(master.rsp.size()));
    foreach (e[i]) chk_val("answer byte", {8'h00, e[i]}, i < master.rsp.size() ? {8'h00, master.rsp[i]} : 16'hFFFF);
  endtask
  task automatic run_row(input dscr_row_s r, input int slow);
    logic [7:0] e[$];
    logic [15:0] k;
    logic pa;
    int b0, b1, b2;
    b0 = n_rst;
    b1 = n_rd;
    b2 = n_wr;
    if (r.exc != 8'h00) e = {8'h01, r.fn | 8'h80, r.exc};
    else if (r.fn == 8'h03) e = {8'h01, r.fn, 8'h02, r.adr[7:0], r.adr[15:8]};
    else e = {8'h01, r.fn, r.adr[15:8], r.adr[7:0], r.val[15:8], r.val[7:0]};
    k = master.crc16(e);
    e.push_back(k[7:0]);
    e.push_back(k[15:8]);
    f = {8'h01, r.fn, r.adr[15:8], r.adr[7:0], r.val[15:8], r.val[7:0]};
    master.send(f, 1'b0);
    master.get_rsp(e.size(), slow);
    pa = r.exc == 8'h00 && r.adr[15:8] < 8'h20;
    chk_rsp(e);
    chk_val("tx valid after answer", 16'h0000, {15'h0000, tx_valid});
    chk_val("drive", {5'h00, r.drv}, {5'h00, drive});
    chk_val("frequency", r.frq, frequency_setpoint);
    chk_val("fault flag", {15'h0000, r.flag}, {15'h0000, external_fault_flag});
    chk_val("fault reset pulses", {15'h0000, r.pulse}, 16'(n_rst - b0));
    chk_val("param reads", {15'h0000, pa && r.fn == 8'h03}, 16'(n_rd - b1));
    chk_val("param writes", {15'h0000, pa && r.fn == 8'h06}, 16'(n_wr - b2));
    if (pa) chk_val("param address", r.adr, param.group_number_address);
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    foreach (rows[i]) run_row(rows[i], (i % 3) * 2);
    // known frame: param write 0100h = 1770h answers crc 86h then 22h
    master.send({8'h01, 8'h06, 8'h01, 8'h00, 8'h17, 8'h70}, 1'b0);
    master.get_rsp(8, 0);
    chk_val("crc low", 16'h0086, 16'(master.rsp[6]));
    chk_val("crc high", 16'h0022, 16'(master.rsp[7]));
    chk_val("param data", 16'h1770, param.wdata);
    // corrupted crc must be dropped without an answer or a write
    master.send({8'h01, 8'h06, 8'h20, 8'h01, 8'h0A, 8'hBC}, 1'b1);
    master.get_rsp(1, 0);
    chk_val("bad frame answer", 16'h0000, 16'(master.rsp.size()));
    chk_val("bad frame frequency", 16'hFFFF, frequency_setpoint);
    // wrong station and a nine-byte frame are dropped too
    master.send({8'h02, 8'h06, 8'h20, 8'h01, 8'h0A, 8'hBC}, 1'b0);
    master.get_rsp(1, 0);
    chk_val("other station answer", 16'h0000, 16'(master.rsp.size()));
    master.send({8'h01, 8'h06, 8'h20, 8'h01, 8'h0A, 8'hBC, 8'h00}, 1'b0);
    master.get_rsp(1, 0);
    chk_val("long frame answer", 16'h0000, 16'(master.rsp.size()));
    chk_val("dropped frame frequency", 16'hFFFF, frequency_setpoint);
    // raise the flag so the reset below has something to clear
    run_row(rows[13], 0);
    // reset in mid-run, then a fresh frame must still check out
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk_val("drive reset", 16'h0100, {5'h00, drive});
    chk_val("frequency reset", 16'h0000, frequency_setpoint);
    chk_val("flag reset", 16'h0000, {15'h0000, external_fault_flag});
    nrst = 1'b1;
    run_row(rows[0], 0);
    end_of_test();
  end
endmodule
